// ==== design/udra_defs.svh ====
// Timing counts and line-level codes for the resume and attach controller.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef UDRA_DEFS_SVH
`define UDRA_DEFS_SVH
// Clock period in picoseconds.
`define UDRA_CLK_PS 4000
// PLL power-up least time in nanoseconds, and cycles rounded up.
`define UDRA_PLL_NS 250000
`define UDRA_PLL_CYC ((`UDRA_PLL_NS * 1000 + `UDRA_CLK_PS - 1) / `UDRA_CLK_PS)
// Two low-speed bit times in picoseconds, and cycles rounded down.
`define UDRA_HS_DLY_PS 1330000
`define UDRA_HS_DLY_CYC (`UDRA_HS_DLY_PS / `UDRA_CLK_PS)
// Line level codes.
`define UDRA_LINE_SE0 2'h0
`define UDRA_LINE_J 2'h1
`define UDRA_LINE_K 2'h2
// Power-state codes.
`define UDRA_PS_SLEEP 2'h0
`define UDRA_PS_ACTIVE 2'h3
// Transceiver choices: speed 1 is full speed, termination 0 is high speed.
`define UDRA_XCVR_FS 1'h1
`define UDRA_XCVR_HS 1'h0
`endif

// ==== design/udra_pkg.sv ====
// Types shared by the resume and attach controller.
// Assumes udra_defs.svh is compiled alongside.
package udra_pkg;
  typedef enum logic [3:0] {
    UDRA_IDLE = 4'h1,
    UDRA_WAIT_K = 4'h2,
    UDRA_RESTORE = 4'h4,
    UDRA_HS_WAIT = 4'h8
  } udra_state_t;
endpackage

// ==== design/udra_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes a free clock and asynchronous active-low reset.
`timescale 1ns/1ps
module udra_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic [2:0] s_reg;
  logic q_reg;

  ////////////////////////////////////////////////////////////////
  // Stage one feeds only stage two; output moves once stages two and three agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= 3'h0;
      q_reg <= 1'h0;
    end else if (ce) begin
      s_reg <= {s_reg[1:0], d};
      if (s_reg[1] == s_reg[2]) begin
        q_reg <= s_reg[2];
      end
    end
  end

  assign q = q_reg;
endmodule

// ==== design/udra_ctrl.sv ====
// Device-side resume detection, speed restore and attach status logic.
// Assumes firmware bits arrive on CLK_SYS; line level and bus power are pins.
`timescale 1ns/1ps
`include "udra_defs.svh"

// Notes on behaviour
// - Resume in suspend sets non-idle status.
// - Non-idle status and enables raise interrupt.
// - J idles in suspend; K means wakeup.
// - Go-active: active state after PLL time.
// - K after suspend exit sets restore flag.
// - K ends: restore speed, clear restore flag.
// - High speed returns 1.33 us after K.
// - Resume end sets restore-complete, gated interrupt.
// - Negotiator ignores cable attach and detach.
// - Bus power pin sets bus-power status.
// - Host reset later; firmware disables bus detect.
module udra_ctrl (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [1:0] BUS_LINE_LEVEL,
  input wire logic BUS_POWER_INPUT_PIN,
  input wire logic IN_SUSPEND_CONTROL,
  input wire logic GO_ACTIVE_REQUEST,
  input wire logic SLEEP_REQUEST,
  input wire logic NEGO_ENABLE,
  input wire logic PRE_SUSPEND_HS,
  input wire logic FW_TRANSCEIVER_SPEED_CHOICE,
  input wire logic FW_TERMINATION_CHOICE,
  input wire logic NON_IDLE_LINE_CLEAR,
  input wire logic RESTORE_COMPLETE_CLEAR,
  input wire logic NON_IDLE_LINE_IRQ_ENABLE,
  input wire logic RESTORE_COMPLETE_IRQ_ENABLE,
  input wire logic SIE_GROUP_IRQ_ENABLE,
  input wire logic DEVICE_GROUP_TOP_IRQ_ENABLE,
  output logic NON_IDLE_LINE_STATUS,
  output logic RESTORE_COMPLETE_STATUS,
  output logic RESTORE_IN_PROGRESS_FLAG,
  output logic BUS_POWER_STATUS,
  output logic [1:0] LINE_LEVEL_STATUS,
  output logic [1:0] POWER_STATE_FIELD,
  output logic CLOCK_ACTIVE,
  output logic TRANSCEIVER_SPEED_CHOICE,
  output logic TERMINATION_CHOICE,
  output logic HS_MODE,
  output logic INTERRUPT_REQUEST_OUT
);
  import udra_pkg::*;

  localparam logic [16:0] PLL_CYC = 17'(`UDRA_PLL_CYC);
  localparam logic [16:0] HS_CYC = 17'(`UDRA_HS_DLY_CYC);

  typedef struct packed {
    udra_state_t st;
    logic [16:0] cnt;
    logic pll_busy;
    logic [16:0] pll_cnt;
    logic [1:0] pstate;
    logic [1:0] line;
    logic non_idle;
    logic restore_cmp;
    logic restore_flag;
    logic speed_hold;
    logic speed;
    logic term;
    logic hs;
    logic irq;
  } udra_regs_t;

  udra_regs_t r_reg;
  udra_regs_t r_next;
  logic [1:0] line_sync;
  logic vbus_sync;
  logic line_k;

  ////////////////////////////////////////////////////////////////
  // Pin inputs cross into CLK_SYS through filtered synchronisers.
  for (genvar i = 0; i < 2; i++) begin : g_line
    udra_sync u_line (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .ce(CE),
      .d(BUS_LINE_LEVEL[i]),
      .q(line_sync[i])
    );
  end

  udra_sync u_vbus (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .ce(CE),
    .d(BUS_POWER_INPUT_PIN),
    .q(vbus_sync)
  );

  assign line_k = (line_sync == `UDRA_LINE_K);

  ////////////////////////////////////////////////////////////////
  // Next-state logic for power state, negotiator and statuses.
  always_comb begin
    r_next = r_reg;
    r_next.line = line_sync;
    // Power management: the clock only starts once the PLL time has run.
    if (SLEEP_REQUEST && !GO_ACTIVE_REQUEST) begin
      r_next.pstate = `UDRA_PS_SLEEP;
      r_next.pll_busy = 1'h0;
    end else if (GO_ACTIVE_REQUEST && r_reg.pstate != `UDRA_PS_ACTIVE && !r_reg.pll_busy) begin
      r_next.pll_busy = 1'h1;
      r_next.pll_cnt = 17'h00000;
    end else if (r_reg.pll_busy) begin
      if (r_reg.pll_cnt >= PLL_CYC) begin
        r_next.pll_busy = 1'h0;
        r_next.pstate = `UDRA_PS_ACTIVE;
      end else begin
        r_next.pll_cnt = r_reg.pll_cnt + 17'h00001;
      end
    end
    // Sticky statuses: a clear in the same cycle as an event loses.
    if (NON_IDLE_LINE_CLEAR) begin
      r_next.non_idle = 1'h0;
    end
    if (RESTORE_COMPLETE_CLEAR) begin
      r_next.restore_cmp = 1'h0;
    end
    if (IN_SUSPEND_CONTROL && NEGO_ENABLE && line_k) begin
      r_next.non_idle = 1'h1;
    end
    // Transceiver choices follow firmware unless a restore holds them; the
    // negotiator never acts on attach or detach itself.
    if (!r_reg.speed_hold) begin
      r_next.speed = FW_TRANSCEIVER_SPEED_CHOICE;
      r_next.term = FW_TERMINATION_CHOICE;
    end
    case (r_reg.st)
      UDRA_IDLE: begin
        if (NEGO_ENABLE && IN_SUSPEND_CONTROL) begin
          r_next.st = UDRA_WAIT_K;
          r_next.hs = 1'h0;
        end
      end
      UDRA_WAIT_K: begin
        if (!NEGO_ENABLE) begin
          r_next.st = UDRA_IDLE;
        end else if (!IN_SUSPEND_CONTROL && line_k && r_reg.pstate == `UDRA_PS_ACTIVE) begin
          r_next.restore_flag = 1'h1;
          r_next.speed_hold = 1'h1;
          r_next.st = UDRA_RESTORE;
        end
      end
      UDRA_RESTORE: begin
        if (!line_k) begin
          r_next.speed = PRE_SUSPEND_HS ? `UDRA_XCVR_HS : `UDRA_XCVR_FS;
          r_next.term = PRE_SUSPEND_HS ? `UDRA_XCVR_HS : `UDRA_XCVR_FS;
          r_next.restore_flag = 1'h0;
          r_next.cnt = 17'h00000;
          r_next.st = UDRA_HS_WAIT;
        end
      end
      UDRA_HS_WAIT: begin
        if (r_reg.cnt >= HS_CYC - 17'h00001) begin
          r_next.hs = PRE_SUSPEND_HS;
          r_next.restore_cmp = 1'h1;
          r_next.speed_hold = 1'h0;
          r_next.st = UDRA_IDLE;
        end else begin
          r_next.cnt = r_reg.cnt + 17'h00001;
        end
      end
      default: begin
        r_next.st = UDRA_IDLE;
      end
    endcase
    // Interrupt uses next statuses so it rises with the status bit.
    r_next.irq = DEVICE_GROUP_TOP_IRQ_ENABLE && SIE_GROUP_IRQ_ENABLE &&
                 ((r_next.non_idle && NON_IDLE_LINE_IRQ_ENABLE) ||
                  (r_next.restore_cmp && RESTORE_COMPLETE_IRQ_ENABLE));
  end

  ////////////////////////////////////////////////////////////////
  // All state registers; clock enable freezes everything.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      r_reg <= '{st: UDRA_IDLE, cnt: 17'h00000, pll_busy: 1'h0, pll_cnt: 17'h00000,
                 pstate: `UDRA_PS_SLEEP, line: `UDRA_LINE_SE0, non_idle: 1'h0,
                 restore_cmp: 1'h0, restore_flag: 1'h0, speed_hold: 1'h0,
                 speed: `UDRA_XCVR_FS, term: `UDRA_XCVR_HS, hs: 1'h0, irq: 1'h0};
    end else if (CE) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs come straight from flip-flops; CLOCK_ACTIVE is decoded from the power state.
  assign NON_IDLE_LINE_STATUS = r_reg.non_idle;
  assign RESTORE_COMPLETE_STATUS = r_reg.restore_cmp;
  assign RESTORE_IN_PROGRESS_FLAG = r_reg.restore_flag;
  assign BUS_POWER_STATUS = vbus_sync;
  assign LINE_LEVEL_STATUS = r_reg.line;
  assign POWER_STATE_FIELD = r_reg.pstate;
  assign CLOCK_ACTIVE = (r_reg.pstate == `UDRA_PS_ACTIVE);
  assign TRANSCEIVER_SPEED_CHOICE = r_reg.speed;
  assign TERMINATION_CHOICE = r_reg.term;
  assign HS_MODE = r_reg.hs;
  assign INTERRUPT_REQUEST_OUT = r_reg.irq;
endmodule

// ==== testbench/udra_checker.sv ====
// Port assertions for the resume and attach controller.
// Assumes one clock domain and CE held high.
`timescale 1ns/1ps
`include "udra_defs.svh"
module udra_checker (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic IN_SUSPEND_CONTROL,
  input wire logic GO_ACTIVE_REQUEST,
  input wire logic PRE_SUSPEND_HS,
  input wire logic NON_IDLE_LINE_CLEAR,
  input wire logic RESTORE_COMPLETE_CLEAR,
  input wire logic NON_IDLE_LINE_IRQ_ENABLE,
  input wire logic RESTORE_COMPLETE_IRQ_ENABLE,
  input wire logic SIE_GROUP_IRQ_ENABLE,
  input wire logic DEVICE_GROUP_TOP_IRQ_ENABLE,
  input wire logic NON_IDLE_LINE_STATUS,
  input wire logic RESTORE_COMPLETE_STATUS,
  input wire logic RESTORE_IN_PROGRESS_FLAG,
  input wire logic [1:0] LINE_LEVEL_STATUS,
  input wire logic CLOCK_ACTIVE,
  input wire logic TRANSCEIVER_SPEED_CHOICE,
  input wire logic HS_MODE,
  input wire logic INTERRUPT_REQUEST_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  int unsigned pll_cnt;
  wire en_n = SIE_GROUP_IRQ_ENABLE && DEVICE_GROUP_TOP_IRQ_ENABLE && NON_IDLE_LINE_IRQ_ENABLE;
  wire en_r = SIE_GROUP_IRQ_ENABLE && DEVICE_GROUP_TOP_IRQ_ENABLE && RESTORE_COMPLETE_IRQ_ENABLE;
  // Counts waiting cycles, since a short PLL wait would hand out an unstable clock.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pll_cnt <= 0;
    end else if (GO_ACTIVE_REQUEST && !CLOCK_ACTIVE) begin
      pll_cnt <= pll_cnt + 1;
    end
  end
  chk_irq_gate: assert property (INTERRUPT_REQUEST_OUT == (($past(en_n) && NON_IDLE_LINE_STATUS) ||
    ($past(en_r) && RESTORE_COMPLETE_STATUS))) else $error("interrupt output wrong");
  chk_non_idle_line_status_sticky: assert property ($fell(NON_IDLE_LINE_STATUS) |-> $past(NON_IDLE_LINE_CLEAR))
    else $error("non-idle status lost");
  chk_rc_sticky: assert property ($fell(RESTORE_COMPLETE_STATUS) |-> $past(RESTORE_COMPLETE_CLEAR))
    else $error("restore status lost");
  chk_pll_time: assert property ($rose(CLOCK_ACTIVE) |-> pll_cnt >= `UDRA_PLL_CYC) else $error("clock too early");
  chk_restore_set: assert property ($rose(RESTORE_IN_PROGRESS_FLAG) |-> !$past(IN_SUSPEND_CONTROL) &&
    CLOCK_ACTIVE && LINE_LEVEL_STATUS == `UDRA_LINE_K) else $error("restore flag without cause");
  chk_speed_restore: assert property ($fell(RESTORE_IN_PROGRESS_FLAG) |->
    TRANSCEIVER_SPEED_CHOICE == !PRE_SUSPEND_HS) else $error("speed not restored");
  chk_hs_delay: assert property ($fell(RESTORE_IN_PROGRESS_FLAG) && PRE_SUSPEND_HS |->
    ##[331:333] $rose(HS_MODE)) else $error("high speed late");
  chk_rc_delay: assert property ($fell(RESTORE_IN_PROGRESS_FLAG) |->
    ##[331:333] $rose(RESTORE_COMPLETE_STATUS)) else $error("restore status late");
  cover property ($rose(NON_IDLE_LINE_STATUS));
  cover property ($fell(RESTORE_IN_PROGRESS_FLAG));
  cover property ($rose(INTERRUPT_REQUEST_OUT));
endmodule
bind udra_ctrl udra_checker udra_checker_i (.*);

// ==== testbench/udra_host_port.sv ====
// Behavioural upstream port driving the two line level pins.
// Assumes the pull-up holds the idle line at J outside resume signalling.
`timescale 1ns/1ps
`include "udra_defs.svh"
module udra_host_port (
  input wire logic clk,
  input wire logic k_req,
  input wire logic se0_req,
  output logic [1:0] line = `UDRA_LINE_J
);
  // K lasts only while commanded, so the bench stands in for the long host timer.
  // A bus reset drives SE0, which takes priority over resume signalling.
  always @(posedge clk) begin
    line <= #1 se0_req ? `UDRA_LINE_SE0 : (k_req ? `UDRA_LINE_K : `UDRA_LINE_J);
  end
endmodule

// ==== testbench/udra_ctrl_tb.sv ====
// Self-checking bench for the resume and attach controller.
// Assumes design, partner model and checker are compiled before it.
`timescale 1ns/1ps
`include "udra_defs.svh"
module udra_ctrl_tb;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, CE = 1'b1, BUS_POWER_INPUT_PIN = 1'b0, k_req = 1'b0, se0_req = 1'b0;
  logic IN_SUSPEND_CONTROL = 1'b0, GO_ACTIVE_REQUEST = 1'b0, SLEEP_REQUEST = 1'b0, NEGO_ENABLE = 1'b0;
  logic PRE_SUSPEND_HS = 1'b1, FW_TRANSCEIVER_SPEED_CHOICE = 1'b1, FW_TERMINATION_CHOICE = 1'b0;
  logic NON_IDLE_LINE_CLEAR = 1'b0, RESTORE_COMPLETE_CLEAR = 1'b0, NON_IDLE_LINE_IRQ_ENABLE = 1'b0;
  logic RESTORE_COMPLETE_IRQ_ENABLE = 1'b0, SIE_GROUP_IRQ_ENABLE = 1'b0, DEVICE_GROUP_TOP_IRQ_ENABLE = 1'b0;
  logic NON_IDLE_LINE_STATUS, RESTORE_COMPLETE_STATUS, RESTORE_IN_PROGRESS_FLAG, BUS_POWER_STATUS, HS_MODE;
  logic CLOCK_ACTIVE, TRANSCEIVER_SPEED_CHOICE, TERMINATION_CHOICE, INTERRUPT_REQUEST_OUT;
  logic [1:0] BUS_LINE_LEVEL, LINE_LEVEL_STATUS, POWER_STATE_FIELD;
  int bad_count = 0, comparisons = 0, cycles = 0, n;
  udra_ctrl udra_ctrl_i (.*);
  udra_host_port udra_host_port_i (.clk(CLK_SYS), .k_req(k_req), .se0_req(se0_req), .line(BUS_LINE_LEVEL));
  // Free-running 250 MHz clock.
  always #2 CLK_SYS = ~CLK_SYS;
  // Cuts a hang short; the whole run needs about 63000 cycles.
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Inputs always move one nanosecond after the edge.
  task automatic tick(input int k);
    repeat (k) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic test_attach;
    chk("speed", 2'h1, 2'(TRANSCEIVER_SPEED_CHOICE));
    chk("power", `UDRA_PS_SLEEP, POWER_STATE_FIELD);
    // With the clock enable low even the pin synchronisers must hold still.
    CE = 1'b0;
    BUS_POWER_INPUT_PIN = 1'b1;
    tick(6);
    chk("frozen", 2'h0, 2'(BUS_POWER_STATUS));
    CE = 1'b1;
    FW_TERMINATION_CHOICE = 1'b1;
    tick(6);
    chk("bus power", 2'h1, 2'(BUS_POWER_STATUS));
    chk("term", 2'h1, 2'(TERMINATION_CHOICE));
    chk("line idle", `UDRA_LINE_J, LINE_LEVEL_STATUS);
    se0_req = 1'b1;
    tick(8);
    chk("host reset", `UDRA_LINE_SE0, LINE_LEVEL_STATUS);
    se0_req = 1'b0;
    tick(8);
    $display("test_attach done");
  endtask
  task automatic test_non_idle_line_status;
    IN_SUSPEND_CONTROL = 1'b1;
    k_req = 1'b1;
    tick(8);
    chk("ignored K", 2'h0, 2'(NON_IDLE_LINE_STATUS));
    k_req = 1'b0;
    NEGO_ENABLE = 1'b1;
    tick(8);
    chk("line", `UDRA_LINE_J, LINE_LEVEL_STATUS);
    k_req = 1'b1;
    tick(8);
    chk("non-idle", 2'h1, 2'(NON_IDLE_LINE_STATUS));
    k_req = 1'b0;
    for (int m = 0; m < 8; m++) begin
      {NON_IDLE_LINE_IRQ_ENABLE, SIE_GROUP_IRQ_ENABLE, DEVICE_GROUP_TOP_IRQ_ENABLE} = 3'(m);
      tick(2);
      chk("irq gate", 2'(m == 7), 2'(INTERRUPT_REQUEST_OUT));
    end
    chk("sticky", 2'h1, 2'(NON_IDLE_LINE_STATUS));
    NON_IDLE_LINE_CLEAR = 1'b1;
    tick(1);
    NON_IDLE_LINE_CLEAR = 1'b0;
    tick(1);
    chk("cleared irq", 2'h0, 2'({NON_IDLE_LINE_STATUS, INTERRUPT_REQUEST_OUT}));
    $display("test_non_idle_line_status done");
  endtask
  task automatic test_resume;
    NON_IDLE_LINE_IRQ_ENABLE = 1'b0;
    RESTORE_COMPLETE_IRQ_ENABLE = 1'b1;
    k_req = 1'b1;
    GO_ACTIVE_REQUEST = 1'b1;
    n = 0;
    while (CLOCK_ACTIVE !== 1'b1 && n < 70000) begin
      tick(1);
      n++;
    end
    chk("pll wait", 2'h1, 2'(n >= 62500 && n < 62510));
    chk("active", `UDRA_PS_ACTIVE, POWER_STATE_FIELD);
    GO_ACTIVE_REQUEST = 1'b0;
    IN_SUSPEND_CONTROL = 1'b0;
    tick(3);
    chk("restore flag", 2'h1, 2'(RESTORE_IN_PROGRESS_FLAG));
    FW_TRANSCEIVER_SPEED_CHOICE = 1'b1;
    k_req = 1'b0;
    n = 0;
    while (RESTORE_IN_PROGRESS_FLAG === 1'b1 && n < 12) begin
      tick(1);
      n++;
    end
    chk("choices", 2'h0, {TRANSCEIVER_SPEED_CHOICE, TERMINATION_CHOICE});
    n = 0;
    while (HS_MODE !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk("hs delay", 2'h1, 2'(n >= 331 && n <= 333));
    chk("complete irq", 2'h3, {RESTORE_COMPLETE_STATUS, INTERRUPT_REQUEST_OUT});
    RESTORE_COMPLETE_CLEAR = 1'b1;
    tick(1);
    RESTORE_COMPLETE_CLEAR = 1'b0;
    tick(1);
    chk("complete clear", 2'h0, {RESTORE_COMPLETE_STATUS, INTERRUPT_REQUEST_OUT});
    $display("test_resume done");
  endtask
  // Reset for six cycles, then the scenarios in bus order.
  initial begin
    tick(6);
    RST_N = 1'b1;
    tick(2);
    test_attach();
    test_non_idle_line_status();
    test_resume();
    close_out();
  end
endmodule
